// ---- rtl/nvac_pkg.sv ----
package nvac_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_LATCH  = 8'h08;
  localparam logic [7:0] OFS_PTR    = 8'h0c;
  localparam logic [7:0] OFS_FLAG   = 8'h10;
  localparam logic [7:0] OFS_TABOP  = 8'h14;

  // Access control field positions
  localparam int BIT_PGM    = 7;
  localparam int BIT_CFG    = 6;
  localparam int BIT_ERASE  = 4;
  localparam int BIT_ABORT  = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_WR     = 1;
  localparam int BIT_RD     = 0;

  // Flag and table-op register fields
  localparam int BIT_DONE   = 0;
  localparam int BIT_TBUSY  = 1;
  localparam int BIT_STORE  = 2;

  // Reset values
  localparam logic [7:0]  RST_CTRL  = 8'h08;
  localparam logic [7:0]  RST_LATCH = 8'h00;
  localparam logic [21:0] RST_PTR   = 22'h000000;

  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // Pointer geometry
  localparam int PTR_W      = 22;
  localparam int ERASE_LSB  = 6;
  localparam int BLOCK_DEF  = 16;

  // Self-timed cycle
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CYCLE_TIME_US = 2000;
  localparam int unsigned CYCLE_CLKS    = CYCLE_TIME_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    PMODE_KEEP,
    PMODE_POST_INC,
    PMODE_POST_DEC,
    PMODE_PRE_INC
  } nvac_pmode_type;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_HALF,
    UNL_ARMED
  } nvac_unlock_type;

  typedef enum logic {
    TAB_IDLE,
    TAB_FETCH
  } nvac_tab_type;

  // Long cycle command toward the flash / EEPROM array
  typedef struct packed {
    logic              busy;
    logic              erase;
    logic              pgm_space;
    logic              cfg_space;
    logic [PTR_W-1:0]  addr;
  } nvac_cycle_type;

  // Byte fetch request toward program memory
  typedef struct packed {
    logic              req;
    logic [PTR_W-1:0]  addr;
  } nvac_fetch_type;

endpackage : nvac_pkg

// ---- rtl/nvac_top.sv ----
`timescale 1ns/1ps
module nvac_top import nvac_pkg::*; #(
  parameter int          BLOCK_BYTES  = BLOCK_DEF,
  parameter int unsigned TIMER_CYCLES = CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Program memory byte fetch
  output nvac_fetch_type                 fetch,
  input  wire logic                      fetch_valid,
  input  wire logic [7:0]                fetch_data,
  // Long cycle toward the array
  output nvac_cycle_type                 cycle,
  output logic      [BLOCK_BYTES*8-1:0]  holding_block,
  // Data EEPROM read strobe
  output logic                           ee_read
);

  localparam int SEL_W = $clog2(BLOCK_BYTES);

  typedef struct packed {
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         slverr;
    logic [7:0]                   ctrl;
    logic                         done;
    logic [7:0]                   latch;
    logic [PTR_W-1:0]             ptr;
    logic [BLOCK_BYTES-1:0][7:0]  hold;
    nvac_unlock_type              unl;
    nvac_tab_type                 tab;
    nvac_pmode_type               tmode;
    nvac_fetch_type               fetch;
    nvac_cycle_type               cycle;
    logic [31:0]                  timer;
    logic                         ee_read;
  } nvac_state_type;

  nvac_state_type s_q;
  nvac_state_type s_d;

  logic             acc;
  logic             wr_done;
  logic [7:0]       wb;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;

  assign acc     = psel && penable && !s_q.ready;
  assign wr_done = psel && penable && s_q.ready && pwrite;
  assign wb      = pwdata[7:0];
  // Top bit held; only the byte address below it moves
  assign ptr_inc = {s_q.ptr[PTR_W-1], s_q.ptr[PTR_W-2:0] + 21'h000001};
  assign ptr_dec = {s_q.ptr[PTR_W-1], s_q.ptr[PTR_W-2:0] - 21'h000001};

  always_comb begin
    s_d         = s_q;
    s_d.ready   = 1'b0;
    s_d.slverr  = 1'b0;
    s_d.ee_read = 1'b0;
    s_d.fetch.req = 1'b0;

    // Read data and error are registered on the same edge as pready
    if (acc) begin
      s_d.ready = 1'b1;
      s_d.rdata = 32'h00000000;
      if (paddr == OFS_CTRL) begin
        s_d.rdata[7:0] = {s_q.ctrl[7:6], 1'b0, s_q.ctrl[4:0]};
      end else if (paddr == OFS_UNLOCK) begin
        s_d.rdata = 32'h00000000;
      end else if (paddr == OFS_LATCH) begin
        s_d.rdata[7:0] = s_q.latch;
      end else if (paddr == OFS_PTR) begin
        s_d.rdata[PTR_W-1:0] = s_q.ptr;
      end else if (paddr == OFS_FLAG) begin
        s_d.rdata[BIT_DONE]  = s_q.done;
        s_d.rdata[BIT_TBUSY] = (s_q.tab != TAB_IDLE);
      end else if (paddr == OFS_TABOP) begin
        s_d.rdata[1:0]       = s_q.tmode;
      end else begin
        s_d.slverr = 1'b1;
      end
    end

    // Register writes take effect at the completing edge
    if (wr_done) begin
      if (paddr == OFS_CTRL) begin
        s_d.ctrl[BIT_PGM]    = wb[BIT_PGM];
        s_d.ctrl[BIT_CFG]    = wb[BIT_CFG];
        s_d.ctrl[BIT_ERASE]  = wb[BIT_ERASE];
        s_d.ctrl[BIT_ABORT]  = wb[BIT_ABORT];
        s_d.ctrl[BIT_PERMIT] = wb[BIT_PERMIT];
        // Set-only triggers; a zero write leaves them alone
        if (wb[BIT_WR] && !s_q.ctrl[BIT_WR]) begin
          s_d.ctrl[BIT_ABORT] = 1'b1;
          if (s_q.unl == UNL_ARMED && s_q.ctrl[BIT_PERMIT]) begin
            s_d.ctrl[BIT_WR]    = 1'b1;
            s_d.timer           = TIMER_CYCLES;
            s_d.cycle.busy      = 1'b1;
            s_d.cycle.erase     = s_q.ctrl[BIT_ERASE];
            s_d.cycle.pgm_space = s_q.ctrl[BIT_PGM];
            s_d.cycle.cfg_space = s_q.ctrl[BIT_CFG];
            if (s_q.ctrl[BIT_ERASE]) begin
              s_d.cycle.addr = {s_q.ptr[PTR_W-1:ERASE_LSB], {ERASE_LSB{1'b0}}};
            end else begin
              s_d.cycle.addr = {s_q.ptr[PTR_W-1:SEL_W], {SEL_W{1'b0}}};
            end
          end
          // Improper attempt: no cycle, abort flag left high
          s_d.unl = UNL_IDLE;
        end
        // Block the read when either space select is set
        if (wb[BIT_RD] && !s_q.ctrl[BIT_PGM] && !s_q.ctrl[BIT_CFG]) begin
          s_d.ctrl[BIT_RD] = 1'b1;
          s_d.ee_read      = 1'b1;
        end
      end else if (paddr == OFS_UNLOCK) begin
        if (wb == KEY_FIRST) begin
          s_d.unl = UNL_HALF;
        end else if (wb == KEY_SECOND && s_q.unl == UNL_HALF) begin
          s_d.unl = UNL_ARMED;
        end else begin
          s_d.unl = UNL_IDLE;
        end
      end else if (paddr == OFS_LATCH) begin
        s_d.latch = wb;
      end else if (paddr == OFS_PTR) begin
        s_d.ptr = pwdata[PTR_W-1:0];
      end else if (paddr == OFS_FLAG) begin
        if (wb[BIT_DONE]) begin
          s_d.done = 1'b0;
        end
      end else if (paddr == OFS_TABOP && s_q.tab == TAB_IDLE) begin
        s_d.tmode = nvac_pmode_type'(pwdata[1:0]);
        if (pwdata[BIT_STORE]) begin
          // Store: pre-increment moves the slot before the write
          if (nvac_pmode_type'(pwdata[1:0]) == PMODE_PRE_INC) begin
            s_d.ptr = ptr_inc;
            s_d.hold[ptr_inc[SEL_W-1:0]] = s_q.latch;
          end else begin
            s_d.hold[s_q.ptr[SEL_W-1:0]] = s_q.latch;
            if (nvac_pmode_type'(pwdata[1:0]) == PMODE_POST_INC) begin
              s_d.ptr = ptr_inc;
            end else if (nvac_pmode_type'(pwdata[1:0]) == PMODE_POST_DEC) begin
              s_d.ptr = ptr_dec;
            end
          end
        end else begin
          s_d.tab       = TAB_FETCH;
          s_d.fetch.req = 1'b1;
          if (nvac_pmode_type'(pwdata[1:0]) == PMODE_PRE_INC) begin
            s_d.ptr        = ptr_inc;
            s_d.fetch.addr = ptr_inc;
          end else begin
            s_d.fetch.addr = s_q.ptr;
          end
        end
      end
    end

    // Table fetch waits for the memory's byte, then applies post modes
    case (s_q.tab)
      TAB_IDLE: begin
      end
      TAB_FETCH: begin
        if (fetch_valid) begin
          s_d.tab   = TAB_IDLE;
          s_d.latch = fetch_data;
          if (s_q.tmode == PMODE_POST_INC) begin
            s_d.ptr = ptr_inc;
          end else if (s_q.tmode == PMODE_POST_DEC) begin
            s_d.ptr = ptr_dec;
          end
        end
      end
      default: begin
        s_d.tab = TAB_IDLE;
      end
    endcase

    // One-cycle EEPROM read clears its own trigger
    if (s_q.ctrl[BIT_RD]) begin
      s_d.ctrl[BIT_RD] = 1'b0;
    end

    // Self-timed cycle; completion overrides a same-cycle software write
    if (s_q.cycle.busy) begin
      if (s_q.timer <= 32'h00000001) begin
        s_d.cycle.busy      = 1'b0;
        s_d.timer           = 32'h00000000;
        s_d.ctrl[BIT_WR]    = 1'b0;
        s_d.ctrl[BIT_ABORT] = 1'b0;
        s_d.done            = 1'b1;
        if (s_q.cycle.erase) begin
          s_d.ctrl[BIT_ERASE] = 1'b0;
        end
      end else begin
        s_d.timer = s_q.timer - 32'h00000001;
      end
    end

    // Unimplemented bit always zero
    s_d.ctrl[5] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      // Abort flag powers up set so an interrupted cycle stays visible
      s_q.ctrl    <= RST_CTRL;
      s_q.latch   <= RST_LATCH;
      s_q.ptr     <= RST_PTR;
      s_q.unl     <= UNL_IDLE;
      s_q.tab     <= TAB_IDLE;
      s_q.tmode   <= PMODE_KEEP;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.rdata;
  assign pready        = s_q.ready;
  assign pslverr       = s_q.slverr;
  assign fetch         = s_q.fetch;
  assign cycle         = s_q.cycle;
  assign holding_block = s_q.hold;
  assign ee_read       = s_q.ee_read;

endmodule : nvac_top

// ---- bench/nvac_props.sv ----
`timescale 1ns/1ps
module nvac_props import nvac_pkg::*; #(
  parameter int          BLOCK_BYTES  = BLOCK_DEF,
  parameter int unsigned TIMER_CYCLES = CYCLE_CLKS
) (
  // Clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // APB
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  // Array side
  input wire nvac_fetch_type fetch,
  input wire nvac_cycle_type cycle,
  input wire logic           ee_read
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counter instead of a long repetition
  logic [31:0] busy_q;
  wire         ctrl_wr = psel && pready && pwrite && paddr == OFS_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      busy_q <= '0;
    else
      busy_q <= cycle.busy ? busy_q + 32'h1 : '0;
  end
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  property p_ready; s_wait |=> pready ##1 !pready; endproperty
  property p_unlock_zero; pready && !pwrite && paddr == OFS_UNLOCK |-> prdata == 32'h0; endproperty
  property p_busy_len; $fell(cycle.busy) |-> busy_q == TIMER_CYCLES; endproperty
  property p_busy_cause; $rose(cycle.busy) |-> $past(ctrl_wr && pwdata[BIT_WR]); endproperty
  property p_erase_align; $rose(cycle.busy) && cycle.erase |-> cycle.addr[5:0] == 6'h0; endproperty
  property p_write_align;
    $rose(cycle.busy) && !cycle.erase && cycle.pgm_space |-> cycle.addr % BLOCK_BYTES == 0;
  endproperty
  property p_rd_cause; ee_read |-> $past(ctrl_wr && pwdata[BIT_RD]) ##1 !ee_read; endproperty
  property p_fetch_pulse; fetch.req |=> !fetch.req && $stable(fetch.addr); endproperty
  a_ready: assert property (p_ready) else $error("pready late or long");
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero");
  a_busy_len: assert property (p_busy_len) else $error("cycle length wrong");
  a_busy_cause: assert property (p_busy_cause) else $error("cycle without trigger");
  a_erase_align: assert property (p_erase_align) else $error("erase address low bits");
  a_write_align: assert property (p_write_align) else $error("write address low bits");
  a_rd_cause: assert property (p_rd_cause) else $error("bad read strobe");
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch request bad");
endmodule : nvac_props
bind nvac_top nvac_props #(.BLOCK_BYTES(BLOCK_BYTES), .TIMER_CYCLES(TIMER_CYCLES)) u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .fetch, .cycle,
  .ee_read);

// ---- bench/nvac_mem_model.sv ----
`timescale 1ns/1ps
module nvac_mem_model import nvac_pkg::*; (
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // Fetch request and answer
  input  wire nvac_fetch_type fetch,
  input  wire logic [3:0]     lat,
  output logic                fetch_valid,
  output logic [7:0]          fetch_data
);
  logic [3:0] wait_q;
  logic       pend_q;
  logic [7:0] noise_q;
  // Data lines churn outside a valid cycle so stale bytes are never taken
  assign fetch_data = fetch_valid ? fetch.addr[7:0] ^ {fetch.addr[21], 7'h0} : noise_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      wait_q <= 4'h0;
      fetch_valid <= 1'b0;
      noise_q <= 8'h00;
    end else begin
      fetch_valid <= 1'b0;
      noise_q <= noise_q + 8'h35;
      if (fetch.req) begin
        pend_q <= 1'b1;
        wait_q <= lat;
      end else if (pend_q) begin
        wait_q <= wait_q - 4'h1;
        if (wait_q == 4'h0) begin
          fetch_valid <= 1'b1;
          pend_q <= 1'b0;
        end
      end
    end
  end
endmodule : nvac_mem_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import nvac_pkg::*;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, fetch_valid, ee_read;
  logic           rerr;
  logic [7:0]     paddr, fetch_data;
  logic [31:0]    pwdata, prdata, rdat;
  logic [3:0]     lat;
  logic [127:0]   hold;
  logic [21:0]    p, fa, np;
  nvac_fetch_type fetch;
  nvac_cycle_type cycle;
  int             num_errors, comparisons, ticks, n_ee;
  nvac_top #(.BLOCK_BYTES(16), .TIMER_CYCLES(24)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fetch, .fetch_valid, .fetch_data,
    .cycle, .holding_block(hold), .ee_read);
  nvac_mem_model mem (.pclk, .presetn, .fetch, .lat, .fetch_valid, .fetch_data);
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    ticks++;
    if (ee_read === 1'b1) n_ee++;
    if (ticks == 20000) begin
      num_errors++;
      wrap_up;
    end
  end
  task wrap_up;
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rdat, e);
  endtask : rdchk
  task tab(input logic [21:0] ptr, input logic [2:0] op);
    apb(1, OFS_PTR, {10'h0, ptr});
    apb(1, OFS_TABOP, {29'h0, op});
    do apb(0, OFS_FLAG, 0); while (rdat[BIT_TBUSY] !== 1'b0);
  endtask : tab
  task trig(input logic [7:0] c, input logic [3:0] e);
    apb(1, OFS_CTRL, {24'h0, c & 8'hfd});
    apb(1, OFS_UNLOCK, 32'h55);
    apb(1, OFS_UNLOCK, 32'haa);
    apb(1, OFS_CTRL, {24'h0, c});
    @(negedge pclk);
    chk({28'h0, cycle.busy, cycle.erase, cycle.pgm_space, cycle.cfg_space}, {28'h0, e});
  endtask : trig
  task wait_idle;
    while (cycle.busy !== 1'b0) @(posedge pclk);
  endtask : wait_idle
  function automatic logic [21:0] inc(logic [21:0] a, logic [20:0] d);
    return {a[21], a[20:0] + d};
  endfunction : inc
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    lat = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdchk(OFS_CTRL, 32'h08);
    rdchk(OFS_PTR, 0);
    apb(1, OFS_PTR, 32'hffffffff);
    rdchk(OFS_PTR, 32'h3fffff);
    apb(1, OFS_LATCH, 32'h1ff);
    rdchk(OFS_LATCH, 32'hff);
    apb(1, OFS_UNLOCK, 32'h55);
    rdchk(OFS_UNLOCK, 0);
    apb(0, 8'h18, 0);
    chk({31'h0, rerr}, 1);
    for (int m = 0; m < 4; m++) begin
      p = 22'h3fffff;
      lat <= 4'(m * 2);
      fa = (m == 3) ? inc(p, 21'h1) : p;
      np = (m == 0) ? p : (m == 2) ? inc(p, 21'h1fffff) : inc(p, 21'h1);
      tab(p, m[2:0]);
      rdchk(OFS_LATCH, {24'h0, fa[7:0] ^ {fa[21], 7'h0}});
      rdchk(OFS_PTR, {10'h0, np});
    end
    apb(1, OFS_LATCH, 32'h77);
    tab(22'h200007, 3'h7);
    rdchk(OFS_PTR, 32'h200008);
    tab(22'h200005, 3'h6);
    rdchk(OFS_PTR, 32'h200004);
    tab(22'h200003, 3'h4);
    rdchk(OFS_PTR, 32'h200003);
    chk({8'h0, hold[71:64], hold[47:40], hold[31:24]}, 32'h777777);
    apb(1, OFS_LATCH, 32'ha5);
    tab(22'h12345f, 3'h5);
    apb(1, OFS_LATCH, 32'h3c);
    tab(22'h123460, 3'h5);
    chk({16'h0, hold[127:120], hold[7:0]}, 32'ha53c);
    trig(8'h82, 4'h0);
    apb(1, OFS_CTRL, 32'h84);
    trig(8'h86, 4'ha) ;
    chk({10'h0, cycle.addr}, 32'h123460);
    rdchk(OFS_CTRL, 32'h8e);
    apb(1, OFS_CTRL, 32'h84);
    apb(0, OFS_CTRL, 0);
    chk(rdat & 32'h2, 32'h2);
    wait_idle;
    rdchk(OFS_CTRL, 32'h84);
    rdchk(OFS_FLAG, 1);
    rdchk(OFS_FLAG, 1);
    apb(1, OFS_FLAG, 1);
    rdchk(OFS_FLAG, 0);
    apb(1, OFS_CTRL, 32'h86);
    @(negedge pclk);
    chk({31'h0, cycle.busy}, 0);
    apb(0, OFS_CTRL, 0);
    chk(rdat & 32'hcc, 32'h8c);
    trig(8'h96, 4'he);
    chk({10'h0, cycle.addr}, 32'h123440);
    wait_idle;
    rdchk(OFS_CTRL, 32'h84);
    trig(8'hc6, 4'hb);
    wait_idle;
    trig(8'h06, 4'h8);
    wait_idle;
    apb(1, OFS_CTRL, 32'h80);
    apb(1, OFS_CTRL, 32'h81);
    apb(1, OFS_CTRL, 32'h40);
    apb(1, OFS_CTRL, 32'h41);
    apb(1, OFS_CTRL, 0);
    apb(1, OFS_CTRL, 1);
    repeat (2) @(posedge pclk);
    chk(32'(n_ee), 1);
    rdchk(OFS_CTRL, 32'h00);
    trig(8'h86, 4'ha);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    chk({28'h0, cycle.busy, cycle.erase, cycle.pgm_space, cycle.cfg_space}, 32'h0);
    rdchk(OFS_CTRL, 32'h08);
    wrap_up;
  end
endmodule : tb
